/* File: qsc_pkg.sv */
// Shared constants, types and register layout for the quad split output control block.
package qsc_pkg;

    // Register byte offsets on the plain register port.
    localparam logic [4:0] QSC_ADDR_CTRL   = 5'h00;
    localparam logic [4:0] QSC_ADDR_OUTSEL = 5'h04;
    localparam logic [4:0] QSC_ADDR_QUADS  = 5'h08;
    localparam logic [4:0] QSC_ADDR_TRIG0  = 5'h0c;
    localparam logic [4:0] QSC_ADDR_TRIG1  = 5'h10;
    localparam logic [4:0] QSC_ADDR_TRIG2  = 5'h14;
    localparam logic [4:0] QSC_ADDR_TRIG3  = 5'h18;
    localparam logic [4:0] QSC_ADDR_STATUS = 5'h1c;

    localparam int QSC_NUM = 4;

    // Frame reference choices.
    typedef enum logic [1:0] {
        QSC_REF_FRAME1 = 2'h0,
        QSC_REF_FRAME2 = 2'h1,
        QSC_REF_EXT    = 2'h2
    } qsc_ref_t;

    // Output standards.
    typedef enum logic [2:0] {
        QSC_FMT_480I_5994  = 3'h0,
        QSC_FMT_720P_5994  = 3'h1,
        QSC_FMT_1080I_5994 = 3'h2,
        QSC_FMT_576I_50    = 3'h3,
        QSC_FMT_720P_50    = 3'h4,
        QSC_FMT_1080I_50   = 3'h5,
        QSC_FMT_1080SF_24  = 3'h6,
        QSC_FMT_1080SF_2398 = 3'h7
    } qsc_fmt_t;

    // Dither levels: off, 2, 3 and 4 bits.
    typedef enum logic [1:0] {
        QSC_DITH_OFF = 2'h0,
        QSC_DITH_LOW = 2'h1,
        QSC_DITH_MED = 2'h2,
        QSC_DITH_HIGH = 2'h3
    } qsc_dith_t;

    // Trigger functions.
    typedef enum logic [2:0] {
        QSC_FN_NONE     = 3'h0,
        QSC_FN_OUT_QUAD = 3'h1,
        QSC_FN_OUT_BKGD = 3'h2,
        QSC_FN_OUT_CYC  = 3'h3,
        QSC_FN_Q_BLACK  = 3'h4,
        QSC_FN_Q_BKGD   = 3'h5,
        QSC_FN_Q_CYC    = 3'h6
    } qsc_fn_t;

    // Output source codes; quadrant codes share them with black in place of the quad view.
    localparam logic [2:0] QSC_SRC_QUAD  = 3'h0;
    localparam logic [2:0] QSC_SRC_BLACK = 3'h0;
    localparam logic [2:0] QSC_SRC_A     = 3'h1;
    localparam logic [2:0] QSC_SRC_D     = 3'h4;

    // Control register layout.
    typedef struct packed {
        logic [3:0] alarm_en;
        logic       clip_white;
        logic       clip_black;
        qsc_dith_t  dither;
        qsc_fmt_t   fmt;
        qsc_ref_t   ref_sel;
    } qsc_ctrl_t;

    // Trigger configuration register layout.
    typedef struct packed {
        logic       level_mode;
        logic       rising;
        logic [2:0] bkgd;
        logic [1:0] target;
        qsc_fn_t    func;
    } qsc_trig_t;

    localparam logic [12:0] QSC_CTRL_RESET   = 13'h1e00;
    localparam logic [11:0] QSC_OUTSEL_RESET = 12'h440;
    localparam logic [11:0] QSC_QUADS_RESET  = 12'h8d1;
    localparam logic [9:0]  QSC_TRIG_RESET   = 10'h000;

    // Nominal black and white sample levels.
    localparam logic [9:0] QSC_BLACK_LEVEL = 10'h040;
    localparam logic [9:0] QSC_WHITE_LEVEL = 10'h3ac;

    // Trigger debounce time.
    localparam int QSC_CLK_KHZ       = 20000;
    localparam int QSC_DEBOUNCE_US   = 1000;
    localparam int QSC_DEBOUNCE_CYC  = (QSC_DEBOUNCE_US * QSC_CLK_KHZ) / 1000;
    localparam logic [15:0] QSC_LFSR_SEED = 16'hace1;

endpackage

/* File: qsc_ctrl.sv */
// Output routing, video clipping and dithering, alarms and trigger handling.
`timescale 1ns/1ps
// Function
// - Lock to frame one, two or external
// - Generate outputs in the selected standard
// - Each output carries quad view or background
// - Reset routing: quad, quad, A, B
// - Dither off by default; 2/3/4 bits
// - Black clip clamps below nominal black
// - White clip clamps above nominal white
// - Enabled alarm rises on lost input
// - Disabled alarm stays quiet
// - Function none has no effect
// - Trigger switches output to quad view
// - Trigger switches output to background
// - Output cycle steps once per trigger
// - Quadrant shows black while triggered
// - Trigger places background into quadrant
// - Quadrant cycle steps through backgrounds, black
// - Rising polarity: rising edge or high
// - Falling polarity: falling edge or low
module qsc_ctrl
    import qsc_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES = QSC_DEBOUNCE_CYC
) (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic [4:0]  addr,
    input  wire logic [31:0] wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic [31:0]      rd_data,
    input  wire logic        frame_start,
    input  wire logic [3:0]  bkgd_lost,
    input  wire logic [3:0]  contact_trigger_input,
    input  wire logic [9:0]  vid_in,
    output logic [9:0]       vid_out,
    output qsc_ref_t         ref_sel,
    output qsc_fmt_t         out_format,
    output logic [3:0][2:0]  out_src,
    output logic [3:0][2:0]  quad_src,
    output logic [3:0]       quad_black,
    output logic [3:0]       alarm
);

    qsc_ctrl_t              ctrl;
    qsc_trig_t [3:0]        trig;
    logic [3:0][2:0]        pend_out;
    logic [3:0][2:0]        pend_quad;
    logic [3:0]             trg_s1;
    logic [3:0]             trg_s2;
    logic [3:0]             trg_stable;
    logic [3:0][15:0]       deb_cnt;
    logic [3:0]             act;
    logic [3:0]             act_d;
    logic [3:0]             fire;
    logic [3:0]             next_black;
    logic [3:0]             lost_s1;
    logic [3:0]             lost_s2;
    logic [15:0]            lfsr;
    logic [9:0]             dmask;
    logic [10:0]            dsum;
    logic [9:0]             dval;

    localparam logic [15:0] DEB_LAST = 16'(DEBOUNCE_CYCLES - 1);

    // Step order A, B, C, D, then quad view or black, then wrap.
    function automatic logic [2:0] step5(input logic [2:0] s);
        return (s >= QSC_SRC_D) ? QSC_SRC_QUAD : s + 3'h1;
    endfunction

    // Low-bit mask for the dither depth.
    function automatic logic [9:0] dith_mask(input qsc_dith_t d);
        case (d)
            QSC_DITH_LOW:  return 10'h003;
            QSC_DITH_MED:  return 10'h007;
            QSC_DITH_HIGH: return 10'h00f;
            default:       return 10'h000;
        endcase
    endfunction

    // Control register writes; reference and format are registered from it one cycle later.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl <= qsc_ctrl_t'(QSC_CTRL_RESET);
        end else if (wr_en && addr == QSC_ADDR_CTRL) begin
            ctrl <= qsc_ctrl_t'(wr_data[12:0]);
        end
    end

    // Reference and format selections follow the control register.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ref_sel    <= QSC_REF_FRAME1;
            out_format <= QSC_FMT_480I_5994;
        end else begin
            ref_sel    <= ctrl.ref_sel;
            out_format <= ctrl.fmt;
        end
    end

    // Trigger configuration registers.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < QSC_NUM; i++) begin
                trig[i] <= qsc_trig_t'(QSC_TRIG_RESET);
            end
        end else if (wr_en) begin
            for (int i = 0; i < QSC_NUM; i++) begin
                if (addr == QSC_ADDR_TRIG0 + 5'(4 * i)) begin
                    trig[i] <= qsc_trig_t'(wr_data[9:0]);
                end
            end
        end
    end

    // Two-flop synchronisers for trigger pins and loss detectors.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            trg_s1  <= 4'hf;
            trg_s2  <= 4'hf;
            lost_s1 <= 4'h0;
            lost_s2 <= 4'h0;
        end else begin
            trg_s1  <= contact_trigger_input;
            trg_s2  <= trg_s1;
            lost_s1 <= bkgd_lost;
            lost_s2 <= lost_s1;
        end
    end

    // Debounce: a new level is accepted once it has held for the full time.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            trg_stable <= 4'hf;
            deb_cnt    <= '0;
        end else begin
            for (int i = 0; i < QSC_NUM; i++) begin
                if (trg_s2[i] == trg_stable[i]) begin
                    deb_cnt[i] <= 16'h0000;
                end else if (deb_cnt[i] >= DEB_LAST) begin
                    trg_stable[i] <= trg_s2[i];
                    deb_cnt[i]    <= 16'h0000;
                end else begin
                    deb_cnt[i] <= deb_cnt[i] + 16'h0001;
                end
            end
        end
    end

    // Polarity turns the clean level into an active flag; mode picks edge or level.
    always_comb begin
        for (int i = 0; i < QSC_NUM; i++) begin
            act[i] = trig[i].rising ? trg_stable[i] : ~trg_stable[i];
            if (trig[i].level_mode) begin
                fire[i] = act[i] & frame_start;
            end else begin
                fire[i] = act[i] & ~act_d[i];
            end
        end
    end

    // Delayed active flag for edge detection.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            act_d <= 4'h0;
        end else begin
            act_d <= act;
        end
    end

    // Pending output routing: software writes first, then triggers on top.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pend_out <= QSC_OUTSEL_RESET;
        end else begin
            if (wr_en && addr == QSC_ADDR_OUTSEL) begin
                pend_out <= wr_data[11:0];
            end
            for (int i = 0; i < QSC_NUM; i++) begin
                if (fire[i]) begin
                    case (trig[i].func)
                        QSC_FN_OUT_QUAD: pend_out[trig[i].target] <= QSC_SRC_QUAD;
                        QSC_FN_OUT_BKGD: pend_out[trig[i].target] <= trig[i].bkgd;
                        QSC_FN_OUT_CYC:
                            pend_out[trig[i].target] <= step5(pend_out[trig[i].target]);
                        default: ;
                    endcase
                end
            end
        end
    end

    // Pending quadrant sources, same priority as the output routing.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pend_quad <= QSC_QUADS_RESET;
        end else begin
            if (wr_en && addr == QSC_ADDR_QUADS) begin
                pend_quad <= wr_data[11:0];
            end
            for (int i = 0; i < QSC_NUM; i++) begin
                if (fire[i]) begin
                    case (trig[i].func)
                        QSC_FN_Q_BKGD: pend_quad[trig[i].target] <= trig[i].bkgd;
                        QSC_FN_Q_CYC:
                            pend_quad[trig[i].target] <= step5(pend_quad[trig[i].target]);
                        default: ;
                    endcase
                end
            end
        end
    end

    // Quadrants held black for as long as their trigger is active.
    always_comb begin
        next_black = 4'h0;
        for (int i = 0; i < QSC_NUM; i++) begin
            if (act[i] && trig[i].func == QSC_FN_Q_BLACK) begin
                next_black[trig[i].target] = 1'b1;
            end
        end
    end

    // Routing changes reach the outputs only on a frame boundary.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            out_src    <= QSC_OUTSEL_RESET;
            quad_src   <= QSC_QUADS_RESET;
            quad_black <= 4'h0;
        end else if (frame_start) begin
            out_src    <= pend_out;
            quad_src   <= pend_quad;
            quad_black <= next_black;
        end
    end

    // Signal loss alarms gated by their enables.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            alarm <= 4'h0;
        end else begin
            alarm <= ctrl.alarm_en & lost_s2;
        end
    end

    // Pseudo-random source for dithering.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            lfsr <= QSC_LFSR_SEED;
        end else begin
            lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        end
    end

    // Dither adds noise below the kept depth, saturates, then drops the low bits.
    always_comb begin
        dmask = dith_mask(ctrl.dither);
        dsum  = {1'b0, vid_in} + {1'b0, lfsr[9:0] & dmask};
        if (dsum[10]) begin
            dval = 10'h3ff & ~dmask;
        end else begin
            dval = dsum[9:0] & ~dmask;
        end
    end

    // Clipping at nominal black and white, then the output register.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            vid_out <= QSC_BLACK_LEVEL;
        end else if (ctrl.clip_black && dval < QSC_BLACK_LEVEL) begin
            vid_out <= QSC_BLACK_LEVEL;
        end else if (ctrl.clip_white && dval > QSC_WHITE_LEVEL) begin
            vid_out <= QSC_WHITE_LEVEL;
        end else begin
            vid_out <= dval;
        end
    end

    // Register reads answer one cycle later; unmapped offsets read zero.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rd_data <= 32'h0000_0000;
        end else if (rd_en) begin
            case (addr)
                QSC_ADDR_CTRL:   rd_data <= {19'h00000, ctrl};
                QSC_ADDR_OUTSEL: rd_data <= {20'h00000, pend_out};
                QSC_ADDR_QUADS:  rd_data <= {20'h00000, pend_quad};
                QSC_ADDR_TRIG0:  rd_data <= {22'h000000, trig[0]};
                QSC_ADDR_TRIG1:  rd_data <= {22'h000000, trig[1]};
                QSC_ADDR_TRIG2:  rd_data <= {22'h000000, trig[2]};
                QSC_ADDR_TRIG3:  rd_data <= {22'h000000, trig[3]};
                QSC_ADDR_STATUS: rd_data <= {16'h0000, quad_black, act, alarm, lost_s2};
                default:         rd_data <= 32'h0000_0000;
            endcase
        end else begin
            rd_data <= 32'h0000_0000;
        end
    end

    // Checks on the behaviour above.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    a_ref_follow: assert property (
        wr_en && addr == QSC_ADDR_CTRL |-> ##2 ref_sel == $past(wr_data[1:0], 2))
        else $error("reference not applied");
    a_fmt_follow: assert property (
        wr_en && addr == QSC_ADDR_CTRL |-> ##2 out_format == $past(wr_data[4:2], 2))
        else $error("format not applied");
    a_out_apply: assert property (
        frame_start |=> out_src == $past(pend_out))
        else $error("routing not applied at frame");
    a_out_hold: assert property (
        !frame_start |=> $stable(out_src) && $stable(quad_src))
        else $error("routing changed mid frame");
    a_alarm_raise: assert property (
        ctrl.alarm_en[0] && lost_s2[0] |=> alarm[0])
        else $error("alarm not raised");
    a_alarm_mask: assert property (
        !ctrl.alarm_en[1] |=> !alarm[1])
        else $error("alarm not suppressed");
    a_clip_black: assert property (
        ctrl.clip_black |=> vid_out >= QSC_BLACK_LEVEL)
        else $error("black not clipped");
    a_clip_white: assert property (
        ctrl.clip_white |=> vid_out <= QSC_WHITE_LEVEL)
        else $error("white not clipped");
    a_dither_off: assert property (
        ctrl.dither == QSC_DITH_OFF && !ctrl.clip_black && !ctrl.clip_white
        |=> vid_out == $past(vid_in))
        else $error("video altered");
    a_none_idle: assert property (
        !wr_en && fire == 4'h2 && trig[1].func == QSC_FN_NONE
        |=> $stable(pend_out) && $stable(pend_quad))
        else $error("idle trigger acted");
    a_cycle_step: assert property (
        !wr_en && fire == 4'h4 && trig[2].func == QSC_FN_OUT_CYC
        |=> pend_out[$past(trig[2].target)] == step5($past(pend_out[trig[2].target])))
        else $error("cycle step wrong");
    a_edge_fire: assert property (
        !trig[2].level_mode && $rose(act[2]) |-> fire[2])
        else $error("edge missed");
    a_out_quad: assert property (
        !wr_en && fire == 4'h1 && trig[0].func == QSC_FN_OUT_QUAD
        |=> pend_out[$past(trig[0].target)] == QSC_SRC_QUAD)
        else $error("quad view not selected");
    a_quad_apply: assert property (
        frame_start |=> quad_src == $past(pend_quad) && quad_black == $past(next_black))
        else $error("quadrants not applied at frame");
    a_level_frame: assert property (
        trig[3].level_mode |-> fire[3] == (act[3] && frame_start))
        else $error("level trigger off frame");

    c_out_cycle:    cover property (fire[2] && trig[2].func == QSC_FN_OUT_CYC);
    c_quad_black:   cover property (quad_black != 4'h0);
    c_alarm:        cover property (alarm != 4'h0);
    c_level_fire:   cover property (fire[3] && trig[3].level_mode);

endmodule

/* File: qsc_contact_model.sv */
// Contact-closure equipment model that drives the four trigger lines.
`timescale 1ns/1ps
module qsc_contact_model #(
    parameter int HOLD = 12
) (
    input  wire logic       sys_clk,
    output logic      [3:0] line
);
    // Open contacts idle high on the pull-up.
    initial line = 4'hf;

    // Moves one line right after a clock edge and holds it long past the debounce time.
    task automatic set_line(input int idx, input logic lvl);
        @(posedge sys_clk);
        line[idx] <= lvl;
        repeat (HOLD) @(posedge sys_clk);
    endtask

    // Closes then opens a contact; act is the level that starts the function.
    task automatic press(input int idx, input logic act);
        set_line(idx, act);
        set_line(idx, ~act);
    endtask

    // A contact bounce far shorter than the debounce time.
    task automatic bounce(input int idx);
        @(posedge sys_clk);
        line[idx] <= 1'b0;
        repeat (2) @(posedge sys_clk);
        line[idx] <= 1'b1;
        repeat (HOLD) @(posedge sys_clk);
    endtask
endmodule

/* File: tb_qsc_ctrl.sv */
// Self-checking testbench for the quad split output control block.
`timescale 1ns/1ps
module tb_qsc_ctrl
    import qsc_pkg::*;
();
    typedef struct packed {
        logic [12:0] ctrl;
        logic [3:0]  lost;
        logic [9:0]  vin;
        logic [9:0]  mask;
        logic [9:0]  exp;
    } qsc_row_t;

    logic            sys_clk = 1'b0;
    logic            resetn = 1'b0;
    logic [4:0]      addr = 5'h00;
    logic [31:0]     wr_data = 32'h0;
    logic            wr_en = 1'b0;
    logic            rd_en = 1'b0;
    logic [31:0]     rd_data;
    logic            frame_start = 1'b0;
    logic [3:0]      bkgd_lost = 4'h0;
    logic [3:0]      trig_line;
    logic [9:0]      vid_in = 10'h200;
    logic [9:0]      vid_out;
    qsc_ref_t        ref_sel;
    qsc_fmt_t        out_format;
    logic [3:0][2:0] out_src;
    logic [3:0][2:0] quad_src;
    logic [3:0]      quad_black;
    logic [3:0]      alarm;
    logic [31:0]     rdv;
    int              n_fail = 0;
    int              total_checks = 0;
    int              cyc = 0;

    // Control word, lost inputs, sample in, mask on the output and expected masked output.
    qsc_row_t rows [8] = '{
        '{13'h1e01, 4'h0, 10'h010, 10'h3ff, 10'h010},
        '{13'h1e86, 4'h5, 10'h010, 10'h3ff, 10'h040},
        '{13'h0108, 4'hf, 10'h3f0, 10'h3ff, 10'h3ac},
        '{13'h078c, 4'hf, 10'h200, 10'h3ff, 10'h200},
        '{13'h1e30, 4'h0, 10'h200, 10'h003, 10'h000},
        '{13'h1e54, 4'h0, 10'h200, 10'h007, 10'h000},
        '{13'h1e78, 4'h0, 10'h200, 10'h00f, 10'h000},
        '{13'h1e1c, 4'hf, 10'h3ff, 10'h3ff, 10'h3ff}
    };

    // Clock at 20 MHz.
    always #25 sys_clk = ~sys_clk;

    qsc_ctrl #(
        .DEBOUNCE_CYCLES(4)
    ) i_dut (
        .sys_clk              (sys_clk),
        .resetn               (resetn),
        .addr                 (addr),
        .wr_data              (wr_data),
        .wr_en                (wr_en),
        .rd_en                (rd_en),
        .rd_data              (rd_data),
        .frame_start          (frame_start),
        .bkgd_lost            (bkgd_lost),
        .contact_trigger_input(trig_line),
        .vid_in               (vid_in),
        .vid_out              (vid_out),
        .ref_sel              (ref_sel),
        .out_format           (out_format),
        .out_src              (out_src),
        .quad_src             (quad_src),
        .quad_black           (quad_black),
        .alarm                (alarm)
    );

    qsc_contact_model i_contact (
        .sys_clk(sys_clk),
        .line   (trig_line)
    );

    // Counts the comparison and reports a mismatch at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [4:0] a);
        @(posedge sys_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        @(negedge sys_clk);
        rdv = rd_data;
    endtask

    // One frame boundary pulse, then time for the routing to land.
    task automatic frame();
        @(posedge sys_clk);
        frame_start <= 1'b1;
        @(posedge sys_clk);
        frame_start <= 1'b0;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    function automatic logic [31:0] tcfg(input logic [2:0] f, input logic [1:0] t,
                                         input logic [2:0] b, input logic r);
        return {22'h0, 1'b0, r, b, t, f};
    endfunction

    task automatic test_done();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // A hang is cut short well past the expected run length.
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            test_done();
        end
    end

    // Reset, then the table, then the trigger cases.
    initial begin
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        @(negedge sys_clk);
        chk(32'(out_src), 32'h440);
        chk(32'(quad_src), 32'h8d1);
        chk(32'({out_format, ref_sel, vid_out, alarm}), 32'h00400);
        rd(QSC_ADDR_CTRL);
        chk(rdv, 32'h1e00);
        rd(5'h1e);
        chk(rdv, 32'h0);
        foreach (rows[i]) begin
            wr(QSC_ADDR_CTRL, 32'(rows[i].ctrl));
            bkgd_lost <= rows[i].lost;
            vid_in    <= rows[i].vin;
            repeat (5) @(posedge sys_clk);
            @(negedge sys_clk);
            chk(32'({out_format, ref_sel}), 32'(rows[i].ctrl[4:0]));
            chk(32'(vid_out & rows[i].mask), 32'(rows[i].exp));
            chk(32'(alarm), 32'(rows[i].ctrl[12:9] & rows[i].lost));
        end
        wr(QSC_ADDR_CTRL, 32'h1e00);
        bkgd_lost <= 4'h0;
        i_contact.press(1, 1'b0);
        frame();
        chk(32'(out_src), 32'h440);
        wr(QSC_ADDR_TRIG0, tcfg(3'h1, 2'h2, 3'h0, 1'b0));
        i_contact.bounce(0);
        frame();
        chk(32'(out_src), 32'h440);
        i_contact.press(0, 1'b0);
        @(negedge sys_clk);
        chk(32'(out_src), 32'h440);
        frame();
        chk(32'(out_src), 32'h400);
        wr(QSC_ADDR_TRIG1, tcfg(3'h2, 2'h0, 3'h4, 1'b0));
        i_contact.press(1, 1'b0);
        frame();
        chk(32'(out_src), 32'h404);
        wr(QSC_ADDR_TRIG2, tcfg(3'h3, 2'h3, 3'h0, 1'b0));
        for (int k = 0; k < 4; k++) begin
            i_contact.press(2, 1'b0);
            frame();
            chk(32'(out_src[3]), 32'((k + 3) % 5));
        end
        wr(QSC_ADDR_TRIG3, tcfg(3'h4, 2'h1, 3'h0, 1'b0));
        i_contact.set_line(3, 1'b0);
        frame();
        chk(32'(quad_black), 32'h2);
        i_contact.set_line(3, 1'b1);
        frame();
        chk(32'(quad_black), 32'h0);
        wr(QSC_ADDR_TRIG0, tcfg(3'h5, 2'h0, 3'h3, 1'b0));
        i_contact.press(0, 1'b0);
        frame();
        chk(32'(quad_src[0]), 32'h3);
        wr(QSC_ADDR_TRIG1, tcfg(3'h6, 2'h3, 3'h0, 1'b0));
        for (int k = 0; k < 4; k++) begin
            i_contact.press(1, 1'b0);
            frame();
            chk(32'(quad_src[3]), 32'(k));
        end
        wr(QSC_ADDR_TRIG2, tcfg(3'h0, 2'h1, 3'h0, 1'b1));
        i_contact.set_line(2, 1'b0);
        wr(QSC_ADDR_TRIG2, tcfg(3'h2, 2'h1, 3'h2, 1'b1));
        i_contact.set_line(2, 1'b1);
        frame();
        chk(32'(out_src[1]), 32'h2);
        // Level mode steps once per frame while the line stays low.
        wr(QSC_ADDR_TRIG3, tcfg(3'h3, 2'h0, 3'h0, 1'b0) | 32'h200);
        i_contact.set_line(3, 1'b0);
        frame();
        chk(32'(out_src[0]), 32'h4);
        frame();
        chk(32'(out_src[0]), 32'h0);
        i_contact.set_line(3, 1'b1);
        frame();
        chk(32'(out_src[0]), 32'h1);
        frame();
        chk(32'(out_src[0]), 32'h1);
        rd(QSC_ADDR_OUTSEL);
        chk(rdv, 32'h211);
        rd(QSC_ADDR_TRIG3);
        chk(rdv, 32'h203);
        // Software routing, quadrant sources and the status word.
        wr(QSC_ADDR_OUTSEL, 32'h088);
        wr(QSC_ADDR_QUADS, 32'h0a3);
        bkgd_lost <= 4'h3;
        frame();
        chk(32'(out_src), 32'h088);
        chk(32'(quad_src), 32'h0a3);
        rd(QSC_ADDR_QUADS);
        chk(rdv, 32'h0a3);
        rd(QSC_ADDR_STATUS);
        chk(rdv, 32'h0433);
        test_done();
    end
endmodule
